// ==== hw/ues_pkg.sv ====
/*
  Shared constants and state types for the half-duplex serial port.
  Assumes one 100 MHz system clock and a synchronous active-high reset.
*/
package ues_pkg;

  localparam int unsigned UES_DATA_BITS = 8;
  localparam logic [2:0] UES_LAST_BIT = 3'h7;
  localparam logic [1:0] UES_GLITCH_CYC = 2'h2;
  localparam logic [15:0] UES_DIV_RESET = 16'h0000;
  localparam logic [7:0] UES_DATA_RESET = 8'h00;

  typedef enum logic [4:0] {
    UES_TX_IDLE = 5'b00001,
    UES_TX_LEAD = 5'b00010,
    UES_TX_START = 5'b00100,
    UES_TX_DATA = 5'b01000,
    UES_TX_STOP = 5'b10000
  } ues_tx_state_t;

  typedef enum logic [5:0] {
    UES_RX_IDLE = 6'b000001,
    UES_RX_START = 6'b000010,
    UES_RX_DATA = 6'b000100,
    UES_RX_STOP = 6'b001000,
    UES_RX_REST = 6'b010000,
    UES_RX_SPARE = 6'b100000
  } ues_rx_state_t;

endpackage : ues_pkg

// ==== hw/ues_baud.sv ====
/*
  Bit-period tick generator, counting system clocks or alternative source pulses.
  Assumes the alternative source arrives as a one-cycle pulse synchronous to clk_sys.
*/
`timescale 1ns/100ps
module ues_baud
  import ues_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic restart,
  input wire logic half,
  input wire logic use_alt,
  input wire logic alt_pulse,
  input wire logic [15:0] div,
  output logic tick
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic src;

  // Period is div+1 source pulses; half load centres receive sampling
  assign src = use_alt ? alt_pulse : 1'b1;
  assign tick = !restart && src && (cnt_q == 16'h0000);
  assign cnt_d = restart ? (half ? {1'b0, div[15:1]} : div) :
                 tick ? div :
                 src ? cnt_q - 16'h0001 : cnt_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cnt_q <= UES_DIV_RESET;
    else if (ce)
      cnt_q <= cnt_d;
  end

endmodule : ues_baud

// ==== hw/ues_port.sv ====
/*
  Half-duplex serial port: transmitter, receiver and direction interlock.
  Assumes txd/rxd pins synchronous to clk_sys and a far end honouring rts_n.
*/
`timescale 1ns/100ps
module ues_port
  import ues_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [15:0] baud_div,
  input wire logic stop_two,
  input wire logic alt_sel,
  input wire logic alt_pulse,
  input wire logic tx_force_pclk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic txd,
  output logic rts_n,
  input wire logic rxd,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err
);

  ues_tx_state_t tx_st_q;
  ues_tx_state_t tx_st_d;
  ues_rx_state_t rx_st_q;
  ues_rx_state_t rx_st_d;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_sh_d;
  logic [2:0] tx_bit_q;
  logic [2:0] tx_bit_d;
  logic tx_stop_q;
  logic tx_stop_d;
  logic tx_alt_q;
  logic tx_alt_d;
  logic [1:0] glitch_q;
  logic [1:0] glitch_d;
  logic txd_q;
  logic txd_d;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_sh_d;
  logic [2:0] rx_bit_q;
  logic [2:0] rx_bit_d;
  logic [7:0] rx_data_q;
  logic rx_valid_q;
  logic rx_err_q;
  logic tx_busy;
  logic rx_busy;
  logic tx_accept;
  logic rx_begin;
  logic tx_tick;
  logic rx_tick;
  logic tx_restart;
  logic rx_restart;
  logic rx_good;
  logic rx_bad;
  logic tx_alt_now;

  assign tx_busy = (tx_st_q != UES_TX_IDLE);
  assign rx_busy = (rx_st_q != UES_RX_IDLE);
  assign tx_ready = !tx_busy && !rx_busy && rxd;
  assign tx_accept = tx_ready && tx_valid;
  assign rx_begin = (rx_st_q == UES_RX_IDLE) && !rxd && !tx_busy;
  // hold off far end while sending
  assign rts_n = tx_busy;
  // system clock timing avoids the glitch
  assign tx_alt_now = alt_sel && !tx_force_pclk;

  assign txd = txd_q;
  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign rx_frame_err = rx_err_q;

  // a second instance gives the other direction
  ues_baud u_tx_baud (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .restart(tx_restart),
    .half(1'b0),
    .use_alt(tx_accept ? tx_alt_now : tx_alt_q),
    .alt_pulse(alt_pulse),
    .div(baud_div),
    .tick(tx_tick)
  );

  ues_baud u_rx_baud (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .restart(rx_restart),
    .half(rx_begin),
    .use_alt(alt_sel),
    .alt_pulse(alt_pulse),
    .div(baud_div),
    .tick(rx_tick)
  );

  // Lead tick reloads by itself; restarting there would feed tick back into tick
  assign tx_restart = tx_accept;
  assign rx_restart = rx_begin;

  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_stop_d = tx_stop_q;
    tx_alt_d = tx_alt_q;
    glitch_d = (glitch_q != 2'h0) ? glitch_q - 2'h1 : 2'h0;
    case (tx_st_q)
      UES_TX_IDLE:
      begin
        if (tx_accept)
        begin
          tx_sh_d = tx_data;
          tx_alt_d = tx_alt_now;
          // alternative source leads with a glitch bit
          tx_st_d = tx_alt_now ? UES_TX_LEAD : UES_TX_START;
          glitch_d = tx_alt_now ? UES_GLITCH_CYC : 2'h0;
        end
      end
      UES_TX_LEAD:
      begin
        if (tx_tick)
          tx_st_d = UES_TX_START;
      end
      UES_TX_START:
      begin
        if (tx_tick)
        begin
          tx_st_d = UES_TX_DATA;
          tx_bit_d = 3'h0;
        end
      end
      UES_TX_DATA:
      begin
        if (tx_tick)
        begin
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = tx_bit_q + 3'h1;
          tx_stop_d = 1'b0;
          if (tx_bit_q == UES_LAST_BIT)
            tx_st_d = UES_TX_STOP;
        end
      end
      UES_TX_STOP:
      begin
        if (tx_tick)
        begin
          tx_stop_d = 1'b1;
          if (tx_stop_q == stop_two)
            tx_st_d = UES_TX_IDLE;
        end
      end
      default:
        tx_st_d = UES_TX_IDLE;
    endcase
  end

  always_comb
  begin
    case (tx_st_d)
      UES_TX_LEAD: txd_d = (glitch_d == 2'h0);
      UES_TX_START: txd_d = 1'b0;
      UES_TX_DATA: txd_d = tx_sh_d[0];
      default: txd_d = 1'b1;
    endcase
  end

  assign rx_good = (rx_st_q == UES_RX_STOP) && rx_tick && rxd;
  assign rx_bad = (rx_st_q == UES_RX_STOP) && rx_tick && !rxd;

  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_bit_d = rx_bit_q;
    case (rx_st_q)
      UES_RX_IDLE:
      begin
        if (rx_begin)
          rx_st_d = UES_RX_START;
      end
      UES_RX_START:
      begin
        // False start unless still low at mid bit
        if (rx_tick)
        begin
          rx_st_d = rxd ? UES_RX_IDLE : UES_RX_DATA;
          rx_bit_d = 3'h0;
        end
      end
      UES_RX_DATA:
      begin
        if (rx_tick)
        begin
          rx_sh_d = {rxd, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == UES_LAST_BIT)
            rx_st_d = UES_RX_STOP;
        end
      end
      UES_RX_STOP:
      begin
        // stop bit sampled here; a recovery bit follows, far end must pad
        if (rx_tick)
          rx_st_d = UES_RX_REST;
      end
      UES_RX_REST:
      begin
        // start edges ignored until this ends
        if (rx_tick)
          rx_st_d = UES_RX_IDLE;
      end
      default:
        rx_st_d = UES_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_st_q <= UES_TX_IDLE;
      tx_sh_q <= UES_DATA_RESET;
      tx_bit_q <= 3'h0;
      tx_stop_q <= 1'b0;
      tx_alt_q <= 1'b0;
      glitch_q <= 2'h0;
      txd_q <= 1'b1;
    end
    else if (ce)
    begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_stop_q <= tx_stop_d;
      tx_alt_q <= tx_alt_d;
      glitch_q <= glitch_d;
      txd_q <= txd_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_st_q <= UES_RX_IDLE;
      rx_sh_q <= UES_DATA_RESET;
      rx_bit_q <= 3'h0;
      rx_data_q <= UES_DATA_RESET;
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_bit_q <= rx_bit_d;
      rx_valid_q <= rx_good;
      rx_err_q <= rx_bad;
      if (rx_good)
        rx_data_q <= rx_sh_q;
    end
  end

  // Frozen cycles suspend checking
  a_dir_exclusive: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    !(tx_busy && rx_busy)) else $error("tx and rx active together");
  a_ready_blocked: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    rx_busy |-> !tx_ready) else $error("tx ready while receiving");
  a_rts_holdoff: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    tx_accept |=> rts_n throughout (tx_busy [*2])) else $error("rts_n low while sending");
  a_glitch_width: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    (tx_st_q == UES_TX_LEAD && $fell(txd_q)) |=> !txd_q ##1 txd_q)
    else $error("glitch not two cycles");
  a_lead_on_alt: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    (tx_accept && tx_alt_now) |=> tx_st_q == UES_TX_LEAD && !txd_q)
    else $error("no lead glitch on alt source");
  a_no_glitch_pclk: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    (tx_accept && !tx_alt_now) |=> tx_st_q == UES_TX_START && !txd_q)
    else $error("pclk start did not begin directly");
  a_frame_levels: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    (tx_st_q == UES_TX_START |-> !txd_q) and
    ((tx_st_q == UES_TX_STOP || tx_st_q == UES_TX_IDLE) |-> txd_q))
    else $error("frame level wrong");
  a_data_lsb: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    (tx_st_q == UES_TX_START && tx_tick) |=> txd_q == tx_sh_q[0] && tx_bit_q == 3'h0)
    else $error("first data bit not lsb");
  a_rx_rest: assert property (@(posedge clk_sys) disable iff (reset || !ce)
    (rx_good || rx_bad) |=> rx_st_q == UES_RX_REST) else $error("no recovery bit");

endmodule : ues_port

// ==== testbench/ues_far_end.sv ====
/*
  Far serial port model: sends framed bytes on rxd, decodes txd.
  Assumes a shared clk_sys and a bit period of BIT cycles.
*/
`timescale 1ns/100ps
module ues_far_end #(parameter int BIT = 6)
(
  input wire logic clk_sys,
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic [7:0] got_q,
  output int got_cnt
);
  logic [7:0] sh;
  initial
  begin
    rxd = 1'b1;
    got_q = 8'h00;
    got_cnt = 0;
  end
  task automatic send(input logic [7:0] b, input logic two, input logic bad);
    int k;
    k = 0;
    while (rts_n !== 1'b0 && k < 1000)
    begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      rxd <= b[i];
      repeat (BIT) @(posedge clk_sys);
    end
    // Bad frame holds the first stop bit low
    rxd <= !bad;
    repeat (BIT) @(posedge clk_sys);
    rxd <= 1'b1;
    repeat (BIT * (1 + two)) @(posedge clk_sys);
  endtask : send
  initial forever
  begin
    @(negedge clk_sys);
    if (txd === 1'b0)
    begin
      repeat (BIT / 2) @(negedge clk_sys);
      if (txd === 1'b0)
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT) @(negedge clk_sys);
          sh[i] = txd;
        end
        repeat (BIT) @(negedge clk_sys);
        got_q = sh;
        got_cnt++;
      end
    end
  end
endmodule : ues_far_end

// ==== testbench/ues_port_tb.sv ====
/*
  Self-checking bench for the half-duplex serial port.
  Assumes alt_pulse every cycle, so both timings match; ce drops only while idle.
*/
`timescale 1ns/100ps
module ues_port_tb;
  localparam int BIT = 6;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic stop_two = 1'b0, alt_sel = 1'b0, tx_force_pclk = 1'b0, tx_valid = 1'b0;
  logic ce = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic txd, rts_n, rxd, tx_ready, rx_valid, rx_frame_err;
  logic [7:0] rx_data, got_q, rx_last = 8'h00, rx_want = 8'h00;
  int got_cnt, rx_cnt = 0, err_cnt = 0, errors = 0, samples_checked = 0;
  integer seed = 32'h2064;
  ues_port ues_port_i (.clk_sys(clk_sys), .reset(reset), .ce(ce), .baud_div(16'h0005),
    .stop_two(stop_two), .alt_sel(alt_sel), .alt_pulse(1'b1), .tx_force_pclk(tx_force_pclk),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .txd(txd), .rts_n(rts_n),
    .rxd(rxd), .rx_data(rx_data), .rx_valid(rx_valid), .rx_frame_err(rx_frame_err));
  ues_far_end #(.BIT(BIT)) ues_far_end_i (.clk_sys(clk_sys), .txd(txd), .rts_n(rts_n),
    .rxd(rxd), .got_q(got_q), .got_cnt(got_cnt));
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic give_up();
    errors++;
    conclude();
  endtask : give_up
  always @(negedge clk_sys)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_cnt++;
      rx_last = rx_data;
    end
    if (rx_frame_err === 1'b1)
      err_cnt++;
  end
  task automatic tx_byte(input logic [7:0] b, input logic alt);
    int n;
    int k;
    n = got_cnt;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      if (++k > 1000)
        give_up();
    end
    while (tx_ready !== 1'b1);
    @(posedge clk_sys);
    tx_valid <= 1'b1;
    tx_data <= b;
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("txd c1", 8'h00, {7'h0, txd});
    chk("rts_n", 8'h01, {7'h0, rts_n});
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk("txd c3", {7'h0, alt}, {7'h0, txd});
    if (alt)
    begin
      repeat (BIT - 2) @(negedge clk_sys);
      chk("start", 8'h00, {7'h0, txd});
    end
    k = 0;
    while (got_cnt == n)
    begin
      @(negedge clk_sys);
      if (++k > 200)
        give_up();
    end
    chk("far rx", b, got_q);
  endtask : tx_byte
  task automatic rx_byte(input logic [7:0] b, input logic bad);
    int n;
    n = rx_cnt;
    if (!bad)
      rx_want = b;
    fork
      ues_far_end_i.send(b, stop_two, bad);
      begin
        repeat (BIT * 3) @(negedge clk_sys);
        chk("tx_ready", 8'h00, {7'h0, tx_ready});
        @(posedge clk_sys);
        tx_valid <= 1'b1;
        repeat (BIT) @(negedge clk_sys);
        chk("txd quiet", 8'h01, {7'h0, txd});
        @(posedge clk_sys);
        tx_valid <= 1'b0;
      end
    join
    chk("rx count", {7'h0, !bad}, 8'(rx_cnt - n));
    chk("rx_data", rx_want, rx_last);
    chk("rx_data hold", rx_want, rx_data);
  endtask : rx_byte
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk("txd idle", 8'h01, {7'h0, txd});
    tx_byte(8'h00, 1'b0);
    tx_byte(8'hff, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      stop_two <= 1'($random(seed));
      tx_byte(8'($random(seed)), 1'b0);
      rx_byte(8'($random(seed)), 1'b0);
    end
    // Frozen port must not take a request
    @(posedge clk_sys);
    ce <= 1'b0;
    tx_valid <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("frozen txd", 8'h01, {7'h0, txd});
    chk("frozen rts_n", 8'h00, {7'h0, rts_n});
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    ce <= 1'b1;
    rx_byte(8'h96, 1'b1);
    @(posedge clk_sys);
    alt_sel <= 1'b1;
    tx_byte(8'($random(seed)), 1'b1);
    @(posedge clk_sys);
    tx_force_pclk <= 1'b1;
    tx_byte(8'h5a, 1'b0);
    chk("frame err", 8'h01, 8'(err_cnt));
    conclude();
  end
endmodule : ues_port_tb
